/* File: hw/crist_top.sv */
// Reset and soft-init architectural state sequencer with AHB-Lite access.
`timescale 1ns/10ps

// Summary of operation
// - Hardware reset loads SIMD control/status with 1F80; soft init keeps it.
// - Hardware reset zeroes time-stamp, perf counter, event select; soft init keeps them.
// - Hardware reset disables fixed and variable range registers; soft init keeps them.
// - Hardware reset enables local interrupt controller; soft init keeps its enable.
// - Top 10 flag bits are undefined after reset; nobody relies on them.
// - Passing self-test leaves accumulator zero; soft init never runs self-test.
// - Version register holds stepping, model, family, type, extended model and family.
// - First fetch after hardware reset is FFFFFFF0, 16 bytes below top.
// - Hardware reset sets code selector F000, base FFFF0000, pointer FFF0.
// - Any bus write of the code selector forms base as selector shifted left 4.
// - Reinitialize empties tags, clears masks, zeroes stack top, nearest, 64-bit.
// - Soft init leaves floating-point state unchanged.
module crist_top #(
  parameter logic [3:0] STEPPING = 4'h1,
  parameter logic [3:0] MODEL = 4'h2,
  parameter logic [3:0] FAMILY = 4'h3,
  parameter logic [1:0] PROC_TYPE = 2'h1,
  parameter logic [3:0] EXT_MODEL = 4'h4,
  parameter logic [7:0] EXT_FAMILY = 8'h05,
  parameter logic [31:0] BUILT_IN_SELF_TEST_RUN_FAIL_CODE = 32'h0000_0001
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic soft_init,
  input wire logic built_in_self_test_run,
  input wire logic self_test_pass,
  input wire logic fpu_reinit_op,
  input wire logic perf_event,
  output logic [31:0] fetch_addr,
  output logic lic_enable,
  output logic [1:0] mem_range_enable,
  output logic [2:0] cache_valid
);
  import crist_pkg::*;

  // ****************************************
  // Elaboration checks
  // ****************************************
  // A zero failure code would hide a failed self-test.
  if (BUILT_IN_SELF_TEST_RUN_FAIL_CODE == 32'h0) begin : g_chk_fail
    $error("BUILT_IN_SELF_TEST_RUN_FAIL_CODE must be nonzero");
  end

  // ****************************************
  // Declarations
  // ****************************************
  crist_state_s st_ff;
  crist_state_s nxt_st;
  crist_state_s init_st;
  crist_req_s req;
  crist_fpu_s fpu;
  logic [31:0] rdata;
  logic fpu_reinit;
  logic [31:0] version_reg;
  // Model registers without a defined reset value.
  logic [31:0] msr_mem [4];

  function automatic logic [3:0] page(input logic [7:0] addr);
    page = addr[7:4];
  endfunction

  function automatic logic [1:0] slot(input logic [7:0] addr);
    slot = addr[3:2];
  endfunction

  // ****************************************
  // Bus front end and floating-point words
  // ****************************************
  crist_ahb u_ahb (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .req(req),
    .rdata(rdata)
  );

  assign fpu_reinit = fpu_reinit_op || (req.wr && req.addr == A_FPU_CMD);

  crist_fpu u_fpu (
    .hclk(hclk),
    .hresetn(hresetn),
    .reinit(fpu_reinit),
    .fpu(fpu)
  );

  // Identity fields; the default values are arbitrary.
  assign version_reg = {4'h0, EXT_FAMILY, EXT_MODEL, 2'h0, PROC_TYPE, FAMILY, MODEL, STEPPING};

  // ****************************************
  // Soft init image
  // ****************************************
  always_comb begin
    init_st = ST_RST;
    init_st.boot_pend = 1'b0;
    init_st.simd = st_ff.simd;
    init_st.tsc = st_ff.tsc + 64'h1;
    init_st.perf = st_ff.perf;
    init_st.evsel = st_ff.evsel;
    init_st.mem_range = st_ff.mem_range;
    init_st.lic = st_ff.lic;
    // Undefined top bits simply keep their old level.
    init_st.flags[31 -: FLAGS_UNDEF_W] = st_ff.flags[31 -: FLAGS_UNDEF_W];
    init_st.pctl = PCTL_BIT4 | (st_ff.pctl & PCTL_CDNW);
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.boot_pend = 1'b0;
    // Strap levels are read on the first edge after release.
    if (st_ff.boot_pend && built_in_self_test_run) begin
      nxt_st.acc = self_test_pass ? 32'h0 : BUILT_IN_SELF_TEST_RUN_FAIL_CODE;
    end
    nxt_st.tsc = st_ff.tsc + 64'h1;
    if (st_ff.evsel[PERF_EN] && perf_event) begin
      nxt_st.perf = st_ff.perf + 32'h1;
    end
    if (soft_init) begin
      nxt_st = init_st;
    end
    if (req.wr) begin
      case (req.addr)
        A_SIMD: nxt_st.simd = req.wdata;
        A_PERF: nxt_st.perf = req.wdata;
        A_EVSEL: nxt_st.evsel = req.wdata;
        A_RANGE: nxt_st.mem_range = req.wdata[1:0];
        A_LIC: nxt_st.lic = req.wdata[0];
        A_FLAGS: nxt_st.flags = req.wdata;
        A_PCTL: nxt_st.pctl = req.wdata;
        A_CS_SEL: begin
          nxt_st.cs_sel = req.wdata[15:0];
          // Until this load the reset base stands.
          nxt_st.cs_base = 32'({req.wdata[15:0], 4'h0});
        end
        A_IP: nxt_st.ip = req.wdata;
        A_CACHE: nxt_st.cache = req.wdata[2:0];
        A_DBG_STAT: nxt_st.dbg_stat = req.wdata;
        A_DBG_CTL: nxt_st.dbg_ctl = req.wdata;
        default: ;
      endcase
      case (page(req.addr))
        PG_TBL_BASE: nxt_st.tbl_base[slot(req.addr)] = req.wdata;
        PG_TBL_LIM: begin
          nxt_st.tbl_lim[slot(req.addr)] = req.wdata[15:0];
          nxt_st.tbl_ar[slot(req.addr)] = req.wdata[17:16];
        end
        PG_DBG_ADDR: nxt_st.dbg_addr[slot(req.addr)] = req.wdata;
        default: ;
      endcase
    end
    nxt_st.fetch = nxt_st.cs_base + nxt_st.ip;
  end

  // Every field, the first fetch address among them, resets to a constant.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Neither reset nor soft init touches these.
  always_ff @(posedge hclk) begin
    if (req.wr && page(req.addr) == PG_MSR) begin
      msr_mem[slot(req.addr)] <= req.wdata;
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  // The counter halves are read separately; a carry between reads is not guarded.
  always_comb begin
    rdata = 32'h0;
    case (req.addr)
      A_SIMD: rdata = st_ff.simd;
      A_TSC_LO: rdata = st_ff.tsc[31:0];
      A_TSC_HI: rdata = st_ff.tsc[63:32];
      A_PERF: rdata = st_ff.perf;
      A_EVSEL: rdata = st_ff.evsel;
      A_RANGE: rdata = {30'h0, st_ff.mem_range};
      A_LIC: rdata = {31'h0, st_ff.lic};
      A_FLAGS: rdata = st_ff.flags;
      A_PCTL: rdata = st_ff.pctl;
      A_ACC: rdata = st_ff.acc;
      A_VER: rdata = version_reg;
      A_FETCH: rdata = st_ff.fetch;
      A_CS_SEL: rdata = {16'h0, st_ff.cs_sel};
      A_CS_BASE: rdata = st_ff.cs_base;
      A_IP: rdata = st_ff.ip;
      A_CACHE: rdata = {29'h0, st_ff.cache};
      A_DBG_STAT: rdata = st_ff.dbg_stat;
      A_DBG_CTL: rdata = st_ff.dbg_ctl;
      A_FPU_CW: rdata = {16'h0, fpu.cw};
      A_FPU_SW: rdata = {16'h0, fpu.sw};
      A_FPU_TAG: rdata = {16'h0, fpu.tag};
      default: ;
    endcase
    case (page(req.addr))
      PG_TBL_BASE: rdata = st_ff.tbl_base[slot(req.addr)];
      PG_TBL_LIM: rdata = {14'h0, st_ff.tbl_ar[slot(req.addr)], st_ff.tbl_lim[slot(req.addr)]};
      PG_DBG_ADDR: rdata = st_ff.dbg_addr[slot(req.addr)];
      PG_MSR: rdata = msr_mem[slot(req.addr)];
      default: ;
    endcase
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign fetch_addr = st_ff.fetch;
  assign lic_enable = st_ff.lic;
  assign mem_range_enable = st_ff.mem_range;
  assign cache_valid = st_ff.cache;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_simd_reset: assert property (st_ff.boot_pend |-> st_ff.simd == SIMD_RST)
    else $error("SIMD control wrong after reset");
  a_simd_init: assert property (soft_init && !req.wr |=> $stable(st_ff.simd))
    else $error("soft init changed SIMD control");
  a_counter_keep: assert property (soft_init |=> st_ff.tsc == $past(st_ff.tsc) + 64'h1)
    else $error("soft init disturbed the time-stamp counter");
  a_counter_reset: assert property (st_ff.boot_pend |-> st_ff.tsc == 64'h0 && st_ff.perf == 32'h0
    && st_ff.evsel == 32'h0)
    else $error("counters not zero after reset");
  a_range_keep: assert property (soft_init && !req.wr |=> $stable(st_ff.mem_range))
    else $error("soft init changed range enables");
  a_range_reset: assert property (st_ff.boot_pend |-> st_ff.mem_range == 2'h0 && st_ff.lic)
    else $error("range or interrupt enable wrong after reset");
  a_lic_keep: assert property (soft_init && !req.wr |=> lic_enable == $past(lic_enable))
    else $error("soft init changed interrupt controller enable");
  a_ctrl_init: assert property (soft_init && !req.wr |=>
    st_ff.pctl == (PCTL_BIT4 | ($past(st_ff.pctl) & PCTL_CDNW)))
    else $error("control register wrong after soft init");
  a_built_in_self_test_run_pass: assert property (st_ff.boot_pend && built_in_self_test_run && self_test_pass
    |=> st_ff.acc == 32'h0 ##1 !st_ff.boot_pend)
    else $error("accumulator not zero after passed self-test");
  a_built_in_self_test_run_fail: assert property (st_ff.boot_pend && built_in_self_test_run && !self_test_pass
    |=> st_ff.acc == BUILT_IN_SELF_TEST_RUN_FAIL_CODE)
    else $error("failed self-test not reported");
  a_no_init_built_in_self_test_run: assert property (soft_init |=> !st_ff.boot_pend)
    else $error("soft init restarted self-test");
  a_first_fetch: assert property (st_ff.boot_pend |-> fetch_addr == FETCH_RST
    && st_ff.cs_sel == CS_SEL_RST && st_ff.cs_base == CS_BASE_RST && st_ff.ip == IP_RST)
    else $error("first fetch state wrong after reset");
  a_seg_load: assert property (req.wr && req.addr == A_CS_SEL && !soft_init |=>
    st_ff.cs_base == 32'({$past(req.wdata[15:0]), 4'h0}) ##1 fetch_addr == $past(st_ff.cs_base) + $past(st_ff.ip))
    else $error("segment base not selector shifted by four");
  a_fpu_keep: assert property (soft_init && !fpu_reinit |=> $stable(fpu))
    else $error("soft init changed floating-point state");
  a_table_init: assert property (soft_init && !req.wr |=> st_ff.tbl_base == '0
    && st_ff.tbl_lim == {4{TBL_LIM_RST}} && st_ff.tbl_ar == {4{TBL_AR_RST}})
    else $error("descriptor tables wrong after soft init");
  a_debug_init: assert property (soft_init && !req.wr |=> st_ff.dbg_addr == '0
    && st_ff.dbg_stat == DBG_STAT_RST && st_ff.dbg_ctl == DBG_CTL_RST)
    else $error("debug registers wrong after soft init");
  a_cache_init: assert property (soft_init && !req.wr |=> cache_valid == 3'h0)
    else $error("caches not invalid after soft init");

endmodule

/* File: hw/crist_pkg.sv */
// Package: register map, layouts and reset state of the reset sequencer.
package crist_pkg;

  // ****************************************
  // Bus encodings
  // ****************************************
  localparam logic [1:0] HT_NONSEQ = 2'h2;
  localparam logic [2:0] HSZ_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic {
    AB_IDLE = 1'b0,
    AB_DATA = 1'b1
  } crist_ahb_e;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] A_SIMD = 8'h00;
  localparam logic [7:0] A_TSC_LO = 8'h04;
  localparam logic [7:0] A_TSC_HI = 8'h08;
  localparam logic [7:0] A_PERF = 8'h0C;
  localparam logic [7:0] A_EVSEL = 8'h10;
  localparam logic [7:0] A_RANGE = 8'h14;
  localparam logic [7:0] A_LIC = 8'h18;
  localparam logic [7:0] A_FLAGS = 8'h1C;
  localparam logic [7:0] A_PCTL = 8'h20;
  localparam logic [7:0] A_ACC = 8'h24;
  localparam logic [7:0] A_VER = 8'h28;
  localparam logic [7:0] A_FETCH = 8'h2C;
  localparam logic [7:0] A_CS_SEL = 8'h30;
  localparam logic [7:0] A_CS_BASE = 8'h34;
  localparam logic [7:0] A_IP = 8'h38;
  localparam logic [7:0] A_CACHE = 8'h3C;
  localparam logic [7:0] A_DBG_STAT = 8'h70;
  localparam logic [7:0] A_DBG_CTL = 8'h74;
  localparam logic [7:0] A_FPU_CW = 8'h80;
  localparam logic [7:0] A_FPU_SW = 8'h84;
  localparam logic [7:0] A_FPU_TAG = 8'h88;
  localparam logic [7:0] A_FPU_CMD = 8'h8C;
  // Pages of four words, slot taken from address bits 3:2.
  localparam logic [3:0] PG_TBL_BASE = 4'h4;
  localparam logic [3:0] PG_TBL_LIM = 4'h5;
  localparam logic [3:0] PG_DBG_ADDR = 4'h6;
  localparam logic [3:0] PG_MSR = 4'h9;

  // ****************************************
  // Field layouts and reset values
  // ****************************************
  localparam int PERF_EN = 22;
  localparam int FLAGS_UNDEF_W = 10;
  localparam logic [31:0] SIMD_RST = 32'h0000_1F80;
  localparam logic [31:0] FLAGS_RST = 32'h0000_0002;
  localparam logic [31:0] PCTL_CDNW = 32'h6000_0000;
  localparam logic [31:0] PCTL_BIT4 = 32'h0000_0010;
  localparam logic [15:0] CS_SEL_RST = 16'hF000;
  localparam logic [31:0] CS_BASE_RST = 32'hFFFF_0000;
  localparam logic [31:0] IP_RST = 32'h0000_FFF0;
  localparam logic [31:0] FETCH_RST = 32'(CS_BASE_RST + IP_RST);
  localparam logic [15:0] TBL_LIM_RST = 16'hFFFF;
  localparam logic [1:0] TBL_AR_RST = 2'h3;
  localparam logic [31:0] DBG_STAT_RST = 32'hFFFF_0FF0;
  localparam logic [31:0] DBG_CTL_RST = 32'h0000_0400;
  localparam int SEG_SHIFT = 4;
  localparam logic [15:0] FPU_CW_RST = 16'h0040;
  localparam logic [15:0] FPU_CW_INIT = 16'h0340;
  localparam logic [15:0] FPU_SW_RST = 16'h0000;
  localparam logic [15:0] FPU_TAG_RST = 16'h5555;
  localparam logic [15:0] FPU_TAG_EMPTY = 16'hFFFF;

  // ****************************************
  // Carriers and state
  // ****************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } crist_req_s;

  typedef struct packed {
    logic [15:0] cw;
    logic [15:0] sw;
    logic [15:0] tag;
  } crist_fpu_s;

  typedef struct packed {
    logic boot_pend;
    logic [31:0] simd;
    logic [63:0] tsc;
    logic [31:0] perf;
    logic [31:0] evsel;
    logic [1:0] mem_range;
    logic lic;
    logic [31:0] flags;
    logic [31:0] pctl;
    logic [31:0] acc;
    logic [15:0] cs_sel;
    logic [31:0] cs_base;
    logic [31:0] ip;
    logic [31:0] fetch;
    logic [2:0] cache;
    logic [3:0][31:0] tbl_base;
    logic [3:0][15:0] tbl_lim;
    logic [3:0][1:0] tbl_ar;
    logic [3:0][31:0] dbg_addr;
    logic [31:0] dbg_stat;
    logic [31:0] dbg_ctl;
  } crist_state_s;

  localparam crist_state_s ST_RST = '{
    boot_pend: 1'b1, simd: SIMD_RST, tsc: '0, perf: '0, evsel: '0,
    mem_range: '0, lic: 1'b1, flags: FLAGS_RST, pctl: PCTL_CDNW | PCTL_BIT4,
    acc: '0, cs_sel: CS_SEL_RST, cs_base: CS_BASE_RST, ip: IP_RST,
    fetch: FETCH_RST, cache: '0, tbl_base: '0, tbl_lim: {4{TBL_LIM_RST}},
    tbl_ar: {4{TBL_AR_RST}}, dbg_addr: '0, dbg_stat: DBG_STAT_RST,
    dbg_ctl: DBG_CTL_RST};

endpackage

/* File: hw/crist_ahb.sv */
// AHB-Lite slave front end: one wait state on every word transfer.
`timescale 1ns/10ps
module crist_ahb (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output crist_pkg::crist_req_s req,
  input wire logic [31:0] rdata
);
  import crist_pkg::*;

  typedef struct packed {
    crist_ahb_e fsm;
    logic wr;
    logic [7:0] addr;
    logic rdy;
    logic [31:0] rdata;
  } crist_ahb_s;

  crist_ahb_s st_ff;
  crist_ahb_s nxt_st;
  logic take;

  // Sub-word transfers are ignored; only whole words are served.
  assign take = hsel && hready && htrans == HT_NONSEQ && hsize == HSZ_WORD;

  always_comb begin
    nxt_st = st_ff;
    req.wr = 1'b0;
    req.rd = 1'b0;
    req.addr = st_ff.addr;
    req.wdata = hwdata;
    case (st_ff.fsm)
      AB_IDLE: begin
        if (take) begin
          nxt_st.fsm = AB_DATA;
          nxt_st.wr = hwrite;
          nxt_st.addr = haddr[7:0];
          nxt_st.rdy = 1'b0;
        end
      end
      AB_DATA: begin
        req.wr = st_ff.wr;
        req.rd = !st_ff.wr;
        nxt_st.fsm = AB_IDLE;
        nxt_st.rdy = 1'b1;
        if (!st_ff.wr) begin
          nxt_st.rdata = rdata;
        end
      end
      default: nxt_st.fsm = AB_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '{fsm: AB_IDLE, wr: 1'b0, addr: '0, rdy: 1'b1, rdata: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hreadyout = st_ff.rdy;
  assign hrdata = st_ff.rdata;
  assign hresp = HRESP_OKAY;

  sequence s_take;
    hsel && hready && htrans == HT_NONSEQ && hsize == HSZ_WORD;
  endsequence
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_bus_wait_state: assert property (@(posedge hclk) disable iff (!hresetn) s_take |=> s_wait)
    else $error("bus transfer not answered after one wait state");

endmodule

/* File: hw/crist_fpu.sv */
// Floating-point control, status and tag words with reinitialize.
`timescale 1ns/10ps
module crist_fpu (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic reinit,
  output crist_pkg::crist_fpu_s fpu
);
  import crist_pkg::*;

  crist_fpu_s st_ff;
  crist_fpu_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    // Tags empty, masks clear, top of stack 0, nearest and 64-bit.
    if (reinit) begin
      nxt_st.cw = FPU_CW_INIT;
      nxt_st.sw = FPU_SW_RST;
      nxt_st.tag = FPU_TAG_EMPTY;
    end
  end

  // Soft init does not reach this block, so its state survives it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '{cw: FPU_CW_RST, sw: FPU_SW_RST, tag: FPU_TAG_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign fpu = st_ff;

  a_fpu_reinit: assert property (@(posedge hclk) disable iff (!hresetn)
    reinit |=> fpu.tag == FPU_TAG_EMPTY && fpu.cw == FPU_CW_INIT && fpu.sw[13:11] == 3'h0)
    else $error("reinitialize did not set the documented state");

endmodule

/* File: sim/crist_boot_model.sv */
// Boot software model: AHB-Lite master issuing single word transfers.
`timescale 1ns/10ps
module crist_boot_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  import crist_pkg::*;

  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSZ_WORD;
    hwdata = 32'h0;
  end

  // ****************************************
  // Bus transfer
  // ****************************************
  // Boot code only makes plain word accesses; it never reloads the code selector by itself.
  // The caller enters at a rising edge, so no wait is assumed: both phases wait on hready.
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
    haddr <= {24'h0, addr};
    hwrite <= wr;
    htrans <= HT_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wdata;
    do @(posedge hclk); while (hready !== 1'b1);
    rdata = hrdata;
  endtask
endmodule

/* File: sim/cpu_reset_init_state_tb.sv */
// Testbench for the reset and soft-init state sequencer.
`timescale 1ns/10ps
module cpu_reset_init_state_tb;
  import crist_pkg::*;

  logic hclk;
  logic hresetn = 1'b0;
  logic soft_init = 1'b0;
  logic built_in_self_test_run = 1'b1;
  logic self_test_pass = 1'b1;
  logic fpu_reinit_op = 1'b0;
  logic perf_event = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, lic_enable;
  logic [1:0] htrans, mem_range_enable;
  logic [2:0] hsize, cache_valid;
  logic [31:0] haddr, hwdata, hrdata, fetch_addr, lo1, lo2;
  logic [31:0] mdl [64];
  int miscompares = 0;
  int n_checks = 0;
  int n;

  // Identification values and failure code are arbitrary; stepping 1 and model 2 stay at their defaults.
  crist_top #(.FAMILY(4'hA), .PROC_TYPE(2'h2), .EXT_MODEL(4'h3),
    .EXT_FAMILY(8'h1B), .BUILT_IN_SELF_TEST_RUN_FAIL_CODE(32'h0000_00A5)) crist_top_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .soft_init(soft_init),
    .built_in_self_test_run(built_in_self_test_run), .self_test_pass(self_test_pass),
    .fpu_reinit_op(fpu_reinit_op), .perf_event(perf_event), .fetch_addr(fetch_addr),
    .lic_enable(lic_enable), .mem_range_enable(mem_range_enable), .cache_valid(cache_valid));

  crist_boot_model crist_boot_model_i (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // ****************************************
  // Reference model of the register words
  // ****************************************
  function automatic void mdl_fpu();
    mdl[32] = 32'h0340;
    mdl[33] = 32'h0;
    mdl[34] = 32'hFFFF;
  endfunction

  // Model words 36 to 39 have no reset, so they are left alone here.
  function automatic void mdl_hard(input logic fail);
    for (int i = 0; i < 36; i++) mdl[i] = 32'h0;
    for (int i = 40; i < 64; i++) mdl[i] = 32'h0;
    mdl[0] = 32'h0000_1F80;
    mdl[6] = 32'h1;
    mdl[7] = 32'h2;
    mdl[8] = 32'h6000_0010;
    mdl[9] = fail ? 32'h0000_00A5 : 32'h0;
    mdl[10] = {4'h0, 8'h1B, 4'h3, 2'h0, 2'h2, 4'hA, 4'h2, 4'h1};
    mdl[11] = 32'hFFFF_FFF0;
    mdl[12] = 32'hF000;
    mdl[13] = 32'hFFFF_0000;
    mdl[14] = 32'hFFF0;
    for (int i = 20; i < 24; i++) mdl[i] = 32'h0003_FFFF;
    mdl[28] = 32'hFFFF_0FF0;
    mdl[29] = 32'h400;
    mdl[32] = 32'h0040;
    mdl[34] = 32'h5555;
  endfunction

  function automatic void mdl_soft();
    logic [31:0] keep [64];
    keep = mdl;
    mdl_hard(1'b0);
    for (int i = 0; i < 36; i++) if (i inside {0, 3, 4, 5, 6, 32, 33, 34}) mdl[i] = keep[i];
    mdl[7] = {keep[7][31:22], 22'h2};
    mdl[8] = 32'h10 | (keep[8] & 32'h6000_0000);
  endfunction

  function automatic void mdl_wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    i = int'(a[7:2]);
    case (i)
      5: mdl[i] = d & 32'h3;
      6: mdl[i] = d & 32'h1;
      15: mdl[i] = d & 32'h7;
      20, 21, 22, 23: mdl[i] = d & 32'h0003_FFFF;
      35: mdl_fpu();
      12: begin
        mdl[12] = {16'h0, d[15:0]};
        mdl[13] = {12'h0, d[15:0], 4'h0};
      end
      default: if (i < 40 && !(i inside {1, 2, 9, 10, 11, 13, 30, 31, 32, 33, 34})) mdl[i] = d;
    endcase
    mdl[11] = mdl[13] + mdl[14];
  endfunction

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    crist_boot_model_i.xfer(1'b1, a, d, r);
    mdl_wr(a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a);
    logic [31:0] d;
    crist_boot_model_i.xfer(1'b0, a, 32'h0, d);
    if (a == 8'h1C) d[31:22] = mdl[7][31:22];
    check(d, mdl[a[7:2]]);
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic sweep(input int top);
    for (int a = 0; a <= top; a += 4) if (a != 'h04 && a != 'h8C) rd_chk(8'(a));
    rd_chk(8'hF0);
    check(fetch_addr, mdl[11]);
    check({31'h0, lic_enable}, mdl[6]);
    check({30'h0, mem_range_enable}, mdl[5]);
    check({29'h0, cache_valid}, mdl[15]);
  endtask

  task automatic hard_reset(input logic run, input logic pass);
    hresetn <= 1'b0;
    built_in_self_test_run <= run;
    self_test_pass <= pass;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    mdl_hard(run && !pass);
  endtask

  task automatic soft_pulse();
    soft_init <= 1'b1;
    @(posedge hclk);
    soft_init <= 1'b0;
    mdl_soft();
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    void'($urandom(32'hF0CC));
    hard_reset(1'b1, 1'b1);
    sweep('h88);
    $display("test power-up state finished");
    for (int a = 0; a <= 'h9C; a += 4) if (a != 'h8C) wr(8'(a), $urandom());
    wr(8'h8C, 32'h0);
    sweep('h9C);
    $display("test register writes finished");
    crist_boot_model_i.xfer(1'b0, 8'h04, 32'h0, lo1);
    soft_pulse();
    crist_boot_model_i.xfer(1'b0, 8'h04, 32'h0, lo2);
    check({31'h0, lo2 > lo1}, 32'h1);
    sweep('h9C);
    $display("test soft init finished");
    wr(8'h10, 32'h0040_0000);
    wr(8'h0C, 32'h0);
    n = $urandom_range(20, 1);
    perf_event <= 1'b1;
    repeat (n) @(posedge hclk);
    perf_event <= 1'b0;
    mdl[3] = 32'(n);
    rd_chk(8'h0C);
    $display("test event count finished");
    // Strap cases: passing run, failing run, no run.
    for (int k = 0; k < 3; k++) begin
      hard_reset(k != 2, k != 1);
      sweep('h88);
      fpu_reinit_op <= 1'b1;
      @(posedge hclk);
      fpu_reinit_op <= 1'b0;
      mdl_fpu();
      soft_pulse();
      sweep('h88);
      $display("test self-test case %0d finished", k);
    end
    final_report();
  end

  // The tests need about 1200 cycles; sixteen times that means a hang.
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    final_report();
  end
endmodule
